// ==== hw/sca_port.sv ====
// Register transfer port of the system control coprocessor
//
// How it works
// - Transfer recognised by 1110 at 27:24, 1111 at 11:8, bit 4 set
// - Direction bit zero writes the coprocessor, one reads it
// - Write transfer copies core register value into addressed register
// - Read transfer returns addressed register into core register
// - Primary register number comes from bits 19 to 16
// - Core register from bits 15:12; program counter must not be named
// - Auxiliary field bits 3:0 gives a register dependent action
// - Secondary opcode bits 7:5 selects operation, zero by default
// - Primary opcode in bits 23:21 is a coprocessor specific code
// - Transfers allowed only from privileged mode, refused from user
// - Data operation, load and store to this unit are undefined
// - Sixteen register locations numbered 0 to 15
// - Locations 0, 5 and 13 chosen further by secondary opcode
// - Location 9 chosen by auxiliary field: lockdown or memory region
// - Fault status records abort cause and domain
// - Fault address holds address of latest data abort
module sca_port #(
  // Arbitrary value
  parameter logic [31:0] IDENT_CODE = 32'h0000_0001,
  parameter logic [31:0] CACHE_INFO = 32'h0,
  parameter logic [31:0] TIGHTLY_COUPLED_MEMORY_STATUS = 32'h0
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire sca_pkg::sca_req_t CP_REQ,
  input wire sca_pkg::sca_abort_t ABORT,
  output sca_pkg::sca_resp_t CP_RESP,
  output sca_pkg::sca_maint_t CACHE_OP,
  output sca_pkg::sca_maint_t TLB_OP,
  output logic [31:0] SYS_CTRL,
  output logic [31:0] PT_BASE,
  output logic [31:0] DOMAIN_PERM,
  output logic [31:0] PROC_ID
);

  // ************************************************************
  // Decode
  // ************************************************************
  sca_pkg::sca_instr_t ins;
  logic is_sys;
  logic is_xfer;
  logic is_other;
  logic priv;
  logic accept;
  logic refuse;
  logic wr_hit;
  logic sel_hit;
  sca_pkg::sca_phys_t sel;
  logic [31:0] rd_val;
  logic [31:0] store [sca_pkg::NPHYS];
  logic [sca_pkg::NPHYS-1:0] hw_set;
  logic [31:0] hw_val [sca_pkg::NPHYS];

  assign ins = CP_REQ.instr;
  assign is_sys = CP_REQ.valid && ins.cpn == sca_pkg::CPNUM_SYS;
  assign is_xfer = is_sys && ins.cls == sca_pkg::CLASS_CP
                   && ins.xfer;
  // Other coprocessor classes aimed here are bounced, never run
  assign is_other = is_sys
                    && ((ins.cls == sca_pkg::CLASS_CP && !ins.xfer)
                    || ins.cls[3:1] == sca_pkg::CLASS_LDST);
  assign priv = CP_REQ.mode != sca_pkg::USER_MODE;
  assign accept = is_xfer && priv
                  && ins.op1 == sca_pkg::OP1_SYS;
  assign refuse = (is_xfer || is_other) && !accept;
  assign wr_hit = accept && !ins.dir && sel_hit;

  // ************************************************************
  // Location to physical register
  // ************************************************************
  always_comb begin
    sel_hit = 1'b1;
    sel = sca_pkg::P_CTRL;
    case (ins.pri)
      sca_pkg::LOC_CTRL: sel = sca_pkg::P_CTRL;
      sca_pkg::LOC_PTB: sel = sca_pkg::P_PTB;
      sca_pkg::LOC_DOM: sel = sca_pkg::P_DOM;
      sca_pkg::LOC_FSR: begin
        if (ins.op2 == sca_pkg::OP2_ALT) begin
          sel = sca_pkg::P_IFSR;
        end else begin
          sel = sca_pkg::P_DFSR;
        end
      end
      sca_pkg::LOC_FAR: sel = sca_pkg::P_FAR;
      sca_pkg::LOC_CACHE: sel = sca_pkg::P_CACHE;
      sca_pkg::LOC_LOCK: begin
        if (ins.aux == sca_pkg::AUX_TCMR) begin
          sel = sca_pkg::P_TCMR;
        end else begin
          sel = sca_pkg::P_CLOCK;
        end
      end
      sca_pkg::LOC_TLBLK: sel = sca_pkg::P_TLBLK;
      sca_pkg::LOC_PID: begin
        if (ins.op2 == sca_pkg::OP2_ALT) begin
          sel = sca_pkg::P_CTX;
        end else begin
          sel = sca_pkg::P_PID;
        end
      end
      sca_pkg::LOC_TEST: sel = sca_pkg::P_TEST;
      // Identity, buffer maintenance and reserved hold no store
      default: sel_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    rd_val = sca_pkg::RST_WORD;
    if (ins.pri == sca_pkg::LOC_IDENT) begin
      case (ins.op2)
        sca_pkg::OP2_ALT: rd_val = CACHE_INFO;
        sca_pkg::OP2_THIRD: rd_val = TIGHTLY_COUPLED_MEMORY_STATUS;
        default: rd_val = IDENT_CODE;
      endcase
    end else if (sel_hit) begin
      rd_val = store[sel];
    end
  end

  // ************************************************************
  // Hardware updates from aborts
  // ************************************************************
  always_comb begin
    for (int k = 0; k < sca_pkg::NPHYS; k++) begin
      hw_set[k] = 1'b0;
      hw_val[k] = sca_pkg::RST_WORD;
    end
    hw_set[sca_pkg::P_DFSR] = ABORT.data;
    hw_val[sca_pkg::P_DFSR] = {sca_pkg::FSR_PAD, ABORT.domain,
                               ABORT.status};
    hw_set[sca_pkg::P_IFSR] = ABORT.fetch;
    hw_val[sca_pkg::P_IFSR] = {sca_pkg::FSR_PAD, ABORT.domain,
                               ABORT.status};
    hw_set[sca_pkg::P_FAR] = ABORT.data;
    hw_val[sca_pkg::P_FAR] = ABORT.addr;
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  // An abort in the same cycle as a software write wins, so a
  // fault record is never lost to a handler's own write
  for (genvar g = 0; g < sca_pkg::NPHYS; g++) begin : g_reg
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
        store[g] <= sca_pkg::RST_WORD;
      end else if (hw_set[g]) begin
        store[g] <= hw_val[g];
      end else if (wr_hit && sel == sca_pkg::sca_phys_t'(g)) begin
        store[g] <= CP_REQ.wdata;
      end
    end
  end

  assign SYS_CTRL = store[sca_pkg::P_CTRL];
  assign PT_BASE = store[sca_pkg::P_PTB];
  assign DOMAIN_PERM = store[sca_pkg::P_DOM];
  assign PROC_ID = store[sca_pkg::P_PID];

  // ************************************************************
  // Answer to the core
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CP_RESP <= '0;
    end else begin
      CP_RESP.done <= accept;
      CP_RESP.undef <= refuse;
      // Naming the program counter gives no writeback at all
      CP_RESP.we <= accept && ins.dir
                    && ins.rd != sca_pkg::PC_REG;
      CP_RESP.idx <= ins.rd;
      if (accept && ins.dir) begin
        CP_RESP.rdata <= rd_val;
      end else begin
        CP_RESP.rdata <= sca_pkg::RST_WORD;
      end
    end
  end

  // ************************************************************
  // Maintenance strobes
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      CACHE_OP <= '0;
    end else begin
      CACHE_OP.valid <= accept && !ins.dir
                        && ins.pri == sca_pkg::LOC_CACHE;
      CACHE_OP.op2 <= ins.op2;
      CACHE_OP.aux <= ins.aux;
      CACHE_OP.data <= CP_REQ.wdata;
    end
  end

  // Reads of this location give zero: the value is undefined
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      TLB_OP <= '0;
    end else begin
      TLB_OP.valid <= accept && !ins.dir
                      && ins.pri == sca_pkg::LOC_TLBOP;
      TLB_OP.op2 <= ins.op2;
      TLB_OP.aux <= ins.aux;
      TLB_OP.data <= CP_REQ.wdata;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  sequence s_user_xfer;
    is_xfer && CP_REQ.mode == sca_pkg::USER_MODE;
  endsequence

  sequence s_refused;
    CP_RESP.undef && !CP_RESP.done && !CP_RESP.we;
  endsequence

  a_user_refused: assert property (
    s_user_xfer |=> s_refused
  ) else $error("user mode transfer not refused");

  a_other_undef: assert property (
    is_sys && ins.cls == sca_pkg::CLASS_CP && !ins.xfer |=> s_refused
  ) else $error("data operation not bounced");

  a_no_pattern: assert property (
    CP_REQ.valid && ins.cpn != sca_pkg::CPNUM_SYS
    |=> !CP_RESP.done && !CP_RESP.undef
  ) else $error("foreign instruction answered");

  a_ctrl_write: assert property (
    accept && !ins.dir && ins.pri == sca_pkg::LOC_CTRL
    |=> SYS_CTRL == $past(CP_REQ.wdata)
  ) else $error("control write not stored");

  a_read_base: assert property (
    accept && ins.dir && ins.pri == sca_pkg::LOC_PTB
    |=> CP_RESP.rdata == PT_BASE && CP_RESP.done
  ) else $error("table base read mismatch");

  a_dir_write: assert property (
    accept && !ins.dir |=> CP_RESP.done && !CP_RESP.we
  ) else $error("write transfer wrote back");

  a_pc_blocked: assert property (
    accept && ins.dir && ins.rd == sca_pkg::PC_REG
    |=> !CP_RESP.we && CP_RESP.idx == sca_pkg::PC_REG
  ) else $error("program counter written");

  a_rsvd_zero: assert property (
    accept && ins.dir && (ins.pri == 4'h4 || ins.pri == 4'hb
    || ins.pri == 4'hc || ins.pri == 4'he)
    |=> CP_RESP.rdata == 32'h0
  ) else $error("reserved location not zero");

  a_fetch_status: assert property (
    accept && ins.dir && ins.pri == sca_pkg::LOC_FSR
    && ins.op2 == sca_pkg::OP2_ALT && !ABORT.fetch
    |=> CP_RESP.rdata == store[sca_pkg::P_IFSR]
  ) else $error("fetch status select wrong");

  a_region_pick: assert property (
    accept && ins.dir && ins.pri == sca_pkg::LOC_LOCK
    && ins.aux == sca_pkg::AUX_TCMR
    |=> CP_RESP.rdata == store[sca_pkg::P_TCMR]
  ) else $error("region select wrong");

  a_abort_rec: assert property (
    ABORT.data |=> store[sca_pkg::P_DFSR][7:0]
    == {$past(ABORT.domain), $past(ABORT.status)}
  ) else $error("abort cause not recorded");

  a_abort_addr: assert property (
    ABORT.data |=> store[sca_pkg::P_FAR] == $past(ABORT.addr)
  ) else $error("abort address not recorded");

  a_tlb_strobe: assert property (
    accept && !ins.dir && ins.pri == sca_pkg::LOC_TLBOP
    |=> TLB_OP.valid ##1 !TLB_OP.valid || $past(accept)
  ) else $error("buffer maintenance not issued");

endmodule

// ==== hw/sca_pkg.sv ====
// Shared types and constants of the system coprocessor transfer port
package sca_pkg;

  // ************************************************************
  // Instruction layout and codes
  // ************************************************************
  typedef struct packed {
    logic [3:0] cond;
    logic [3:0] cls;
    logic [2:0] op1;
    logic       dir;
    logic [3:0] pri;
    logic [3:0] rd;
    logic [3:0] cpn;
    logic [2:0] op2;
    logic       xfer;
    logic [3:0] aux;
  } sca_instr_t;

  localparam logic [3:0] CLASS_CP = 4'he;
  localparam logic [2:0] CLASS_LDST = 3'h6;
  localparam logic [3:0] CPNUM_SYS = 4'hf;
  localparam logic [3:0] PC_REG = 4'hf;
  localparam logic [2:0] OP1_SYS = 3'h0;
  localparam logic [4:0] USER_MODE = 5'h10;

  // ************************************************************
  // Register locations and selectors
  // ************************************************************
  localparam logic [3:0] LOC_IDENT = 4'h0;
  localparam logic [3:0] LOC_CTRL = 4'h1;
  localparam logic [3:0] LOC_PTB = 4'h2;
  localparam logic [3:0] LOC_DOM = 4'h3;
  localparam logic [3:0] LOC_FSR = 4'h5;
  localparam logic [3:0] LOC_FAR = 4'h6;
  localparam logic [3:0] LOC_CACHE = 4'h7;
  localparam logic [3:0] LOC_TLBOP = 4'h8;
  localparam logic [3:0] LOC_LOCK = 4'h9;
  localparam logic [3:0] LOC_TLBLK = 4'ha;
  localparam logic [3:0] LOC_PID = 4'hd;
  localparam logic [3:0] LOC_TEST = 4'hf;
  localparam logic [2:0] OP2_PRIMARY = 3'h0;
  localparam logic [2:0] OP2_ALT = 3'h1;
  localparam logic [2:0] OP2_THIRD = 3'h2;
  localparam logic [3:0] AUX_TCMR = 4'h1;

  typedef enum logic [3:0] {
    P_CTRL, P_PTB, P_DOM, P_DFSR, P_IFSR, P_FAR, P_CACHE,
    P_CLOCK, P_TCMR, P_TLBLK, P_PID, P_CTX, P_TEST
  } sca_phys_t;
  localparam int NPHYS = 13;

  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [23:0] FSR_PAD = 24'h0;

  // ************************************************************
  // Port carriers
  // ************************************************************
  typedef struct packed {
    logic       valid;
    logic [4:0] mode;
    sca_instr_t instr;
    logic [31:0] wdata;
  } sca_req_t;

  typedef struct packed {
    logic       done;
    logic       undef;
    logic       we;
    logic [3:0] idx;
    logic [31:0] rdata;
  } sca_resp_t;

  typedef struct packed {
    logic       data;
    logic       fetch;
    logic [3:0] status;
    logic [3:0] domain;
    logic [31:0] addr;
  } sca_abort_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] op2;
    logic [3:0] aux;
    logic [31:0] data;
  } sca_maint_t;

endpackage

// ==== verification/sca_core_model.sv ====
// Core model that issues coprocessor transfer instructions to the port
module sca_core_model (
  input wire logic CLK_SYS,
  output sca_pkg::sca_req_t CP_REQ,
  input wire sca_pkg::sca_resp_t CP_RESP
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    CP_REQ = '0;
  end

  // ************************************************************
  // Transfer issue
  // ************************************************************
  // Called just after an edge; rel low keeps valid up so the next call
  // follows back to back without dropping it in between
  task automatic xfer(input logic [4:0] mode,
                      input sca_pkg::sca_instr_t instr,
                      input logic [31:0] wdata, input bit rel,
                      output sca_pkg::sca_resp_t resp);
    if (!CP_REQ.valid) begin
      // A released request sees one edge low before it is raised again
      @(posedge CLK_SYS);
      #1;
    end
    CP_REQ.valid = 1'b1;
    CP_REQ.mode = mode;
    CP_REQ.instr = instr;
    CP_REQ.wdata = wdata;
    @(posedge CLK_SYS);
    #1;
    resp = CP_RESP;
    if (rel) begin
      CP_REQ.valid = 1'b0;
      // An idle bus must not keep showing the last word
      CP_REQ.instr = ~instr;
      CP_REQ.wdata = ~wdata;
    end
  endtask
endmodule

// ==== verification/sca_bench.sv ====
// Self-checking bench of the coprocessor transfer port
`define CHK(name, exp, got) begin n_compared++; \
  if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", name, exp, got); end end

module system_coprocessor_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PRIV = 5'h13;
  // Arbitrary values
  localparam logic [31:0] ID = 32'h0000_0a5c;
  localparam logic [31:0] CI = 32'h0000_0c11;
  localparam logic [31:0] TS = 32'h0000_0d22;
  logic CLK_SYS, RSTN;
  sca_pkg::sca_req_t cp_req;
  sca_pkg::sca_abort_t abort;
  sca_pkg::sca_resp_t cp_resp, r;
  sca_pkg::sca_maint_t cache_op, tlb_op;
  logic [31:0] sys_ctrl, pt_base, domain_perm, proc_id;
  logic [31:0] ws [13];
  logic [3:0] tp [13] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h5, 4'h6, 4'h7,
                          4'h9, 4'h9, 4'ha, 4'hd, 4'hd, 4'hf};
  logic [2:0] to [13] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0,
                          3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0};
  logic [3:0] rsv [4] = '{4'h4, 4'hb, 4'hc, 4'he};
  int num_errors, n_compared;

  sca_port #(.IDENT_CODE(ID), .CACHE_INFO(CI), .TIGHTLY_COUPLED_MEMORY_STATUS(TS)) sca_port_i (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CP_REQ(cp_req), .ABORT(abort),
    .CP_RESP(cp_resp), .CACHE_OP(cache_op), .TLB_OP(tlb_op),
    .SYS_CTRL(sys_ctrl), .PT_BASE(pt_base), .DOMAIN_PERM(domain_perm),
    .PROC_ID(proc_id));
  sca_core_model sca_core_model_i (
    .CLK_SYS(CLK_SYS), .CP_REQ(cp_req), .CP_RESP(cp_resp));

  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  function automatic sca_pkg::sca_instr_t mk(logic [2:0] op1, logic dir,
      logic [3:0] pri, logic [3:0] rd, logic [2:0] op2, logic [3:0] aux);
    return '{4'he, sca_pkg::CLASS_CP, op1, dir, pri, rd,
             sca_pkg::CPNUM_SYS, op2, 1'b1, aux};
  endfunction

  task automatic wr(logic [3:0] pri, logic [2:0] op2, logic [3:0] aux,
                    logic [31:0] w);
    sca_core_model_i.xfer(PRIV, mk(3'h0, 1'b0, pri, 4'h2, op2, aux), w,
                          1'b1, r);
    `CHK("write done", 1'b1, r.done)
  endtask

  task automatic rd(logic [3:0] pri, logic [2:0] op2, logic [3:0] aux,
                    logic [31:0] exp);
    sca_core_model_i.xfer(PRIV, mk(3'h0, 1'b1, pri, 4'h5, op2, aux),
                          32'h0, 1'b1, r);
    `CHK("read done", 1'b1, r.done)
    `CHK("read we", 1'b1, r.we)
    `CHK("read idx", 4'h5, r.idx)
    `CHK("read data", exp, r.rdata)
  endtask

  task automatic bad(logic [4:0] mode, sca_pkg::sca_instr_t ins,
                     logic undef);
    sca_core_model_i.xfer(mode, ins, 32'hffff_ffff, 1'b1, r);
    `CHK("undef", undef, r.undef)
    `CHK("no done", 1'b0, r.done)
  endtask

  task automatic hit(logic dt, logic [3:0] st, logic [3:0] dm,
                     logic [31:0] ad);
    abort = '{dt, ~dt, st, dm, ad};
    @(posedge CLK_SYS);
    #1;
    // Idle abort lines carry junk so a stale capture shows up
    abort = '{1'b0, 1'b0, ~st, ~dm, ~ad};
  endtask

  task automatic results;
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    sca_sc_sequence();
  end

  initial begin
    #200000;
    num_errors++;
    results();
  end

  task automatic sca_sc_sequence;
    sca_pkg::sca_instr_t ins;
    RSTN = 1'b0;
    abort = '0;
    num_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge CLK_SYS);
    #1;
    RSTN = 1'b1;
    `CHK("ctrl at reset", 32'h0, sys_ctrl)
    for (int i = 0; i < 13; i++) begin
      ws[i] = (tp[i] == 4'h5) ? {24'h0, 4'h9, 4'(i)} :
              {tp[i], 1'b0, to[i], 4'(i == 8), 12'hc3a, 8'(i)};
      rd(tp[i], to[i], 4'(i == 8), 32'h0);
      wr(tp[i], to[i], 4'(i == 8), ws[i]);
      `CHK("cache op", tp[i] == 4'h7, cache_op.valid)
      rd(tp[i], to[i], 4'(i == 8), ws[i]);
    end
    for (int i = 0; i < 13; i++)
      rd(tp[i], to[i], 4'(i == 8), ws[i]);
    `CHK("ctrl out", ws[0], sys_ctrl)
    `CHK("base out", ws[1], pt_base)
    `CHK("domain out", ws[2], domain_perm)
    `CHK("pid out", ws[10], proc_id)
    for (int i = 0; i < 4; i++) begin
      wr(rsv[i], 3'h0, 4'h0, 32'hffff_ffff);
      rd(rsv[i], 3'h0, 4'h0, 32'h0);
    end
    wr(4'h0, 3'h0, 4'h0, 32'h1234_5678);
    rd(4'h0, 3'h0, 4'h0, ID);
    rd(4'h0, 3'h1, 4'h0, CI);
    rd(4'h0, 3'h2, 4'h0, TS);
    wr(4'h8, 3'h3, 4'h6, 32'h0000_8001);
    `CHK("tlb op", 1'b1, tlb_op.valid)
    `CHK("tlb data", 32'h0000_8001, tlb_op.data)
    `CHK("tlb aux", 4'h6, tlb_op.aux)
    `CHK("tlb op2", 3'h3, tlb_op.op2)
    rd(4'h8, 3'h0, 4'h0, 32'h0);
    `CHK("tlb once", 1'b0, tlb_op.valid)
    wr(4'h7, 3'h4, 4'ha, 32'h0000_5aa5);
    `CHK("cache op2", 3'h4, cache_op.op2)
    `CHK("cache aux", 4'ha, cache_op.aux)
    `CHK("cache data", 32'h0000_5aa5, cache_op.data)
    bad(sca_pkg::USER_MODE, mk(3'h0, 1'b0, 4'h1, 4'h2, 3'h0, 4'h0),
        1'b1);
    bad(sca_pkg::USER_MODE, mk(3'h0, 1'b1, 4'h1, 4'h2, 3'h0, 4'h0),
        1'b1);
    bad(PRIV, mk(3'h1, 1'b0, 4'h1, 4'h2, 3'h0, 4'h0), 1'b1);
    ins = mk(3'h0, 1'b0, 4'h1, 4'h2, 3'h0, 4'h0);
    ins.xfer = 1'b0;
    bad(PRIV, ins, 1'b1);
    ins.cls = 4'hc;
    bad(PRIV, ins, 1'b1);
    ins = mk(3'h0, 1'b0, 4'h1, 4'h2, 3'h0, 4'h0);
    ins.cpn = 4'he;
    bad(PRIV, ins, 1'b0);
    rd(4'h1, 3'h0, 4'h0, ws[0]);
    sca_core_model_i.xfer(PRIV, mk(3'h0, 1'b1, 4'h1, 4'hf, 3'h0, 4'h0),
                          32'h0, 1'b1, r);
    `CHK("pc read we", 1'b0, r.we)
    sca_core_model_i.xfer(PRIV, mk(3'h0, 1'b0, 4'h2, 4'h2, 3'h0, 4'h0),
                          32'h6b6b_0001, 1'b0, r);
    rd(4'h2, 3'h0, 4'h0, 32'h6b6b_0001);
    hit(1'b1, 4'h7, 4'h3, 32'h7e10_0040);
    rd(4'h5, 3'h0, 4'h0, 32'h0000_0037);
    rd(4'h6, 3'h0, 4'h0, 32'h7e10_0040);
    hit(1'b0, 4'h5, 4'hb, 32'h0000_1000);
    rd(4'h5, 3'h1, 4'h0, 32'h0000_00b5);
    rd(4'h5, 3'h0, 4'h0, 32'h0000_0037);
    rd(4'h6, 3'h0, 4'h0, 32'h7e10_0040);
    results();
  endtask
endmodule
